// File: btob_core.sv
// Execute logic for bit invert and branch on overflow
`include "btob_regs.svh"

module btob_core
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // Instruction
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [20:0] instr_addr_i,
  // Core state
  input  wire logic        ovf_flag_i,
  input  wire logic        ext_set_en_i,
  input  wire logic [3:0]  bank_select_reg_i,
  input  wire logic [11:0] index_base_i,
  // Data memory
  output logic [11:0]      dmem_addr_o,
  output logic             dmem_rd_o,
  input  wire logic [7:0]  dmem_rdata_i,
  output logic             dmem_wr_o,
  output logic [7:0]       dmem_wdata_o,
  // Program counter and status
  output logic             pc_load_o,
  output logic [20:0]      pc_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             unknown_o
);

  btob_pkg::btob_state_t state;
  logic [7:0]            bit_mask;
  logic                  is_invert;
  logic                  is_branch;
  logic                  take_inv;
  logic                  take_br;
  logic [20:0]           next_seq_pc;
  logic [20:0]           next_target;
  logic [7:0]            next_mask;
  logic [7:0]            toggled;

  btob_addr_if aif ();

  assign aif.file_off   = instr_i[7:0];
  assign aif.bank_sel   = instr_i[8];
  assign aif.ext_en     = ext_set_en_i;
  assign aif.bank_reg   = bank_select_reg_i;
  assign aif.index_base = index_base_i;

  btob_addr_calc u_addr
  (
    .aif (aif.calc)
  );

  assign is_invert   = (instr_i[15:12] == `BTOB_INV_PREFIX);
  assign is_branch   = (instr_i[15:8] == `BTOB_BR_PREFIX);
  assign take_inv    = instr_valid_i && (state == btob_pkg::ST_IDLE) && is_invert;
  assign take_br     = instr_valid_i && (state == btob_pkg::ST_IDLE) && is_branch;
  assign next_seq_pc = instr_addr_i + `BTOB_PC_STEP;
  // Offset sign-extended and doubled; PC already points past the branch
  assign next_target = next_seq_pc + {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
  assign next_mask   = 8'h01 << instr_i[11:9];
  assign toggled     = dmem_rdata_i ^ bit_mask;

  // Sequencer: read, modify, write back
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      state <= btob_pkg::ST_IDLE;
    end
    else
    begin
      case (state)
        btob_pkg::ST_IDLE:
        begin
          if (take_inv)
          begin
            state <= btob_pkg::ST_READ;
          end
        end
        btob_pkg::ST_READ:  state <= btob_pkg::ST_MOD;
        btob_pkg::ST_MOD:   state <= btob_pkg::ST_WRITE;
        btob_pkg::ST_WRITE: state <= btob_pkg::ST_IDLE;
        default:            state <= btob_pkg::ST_IDLE;
      endcase
    end
  end

  // Memory side
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      dmem_addr_o  <= 12'h000;
      dmem_rd_o    <= 1'b0;
      dmem_wr_o    <= 1'b0;
      dmem_wdata_o <= 8'h00;
      bit_mask     <= 8'h00;
    end
    else
    begin
      dmem_rd_o <= take_inv;
      if (take_inv)
      begin
        dmem_addr_o <= aif.data_addr;
        bit_mask    <= next_mask;
      end
      // Read data are valid one cycle after the strobe
      if (state == btob_pkg::ST_MOD)
      begin
        dmem_wdata_o <= toggled;
      end
      dmem_wr_o <= (state == btob_pkg::ST_MOD);
    end
  end

  // Program counter side; no status flag is ever touched here
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      pc_load_o <= 1'b0;
      pc_o      <= 21'h000000;
    end
    else
    begin
      pc_load_o <= take_br && ovf_flag_i;
      if (take_br)
      begin
        pc_o <= ovf_flag_i ? next_target : next_seq_pc;
      end
    end
  end

  // Handshake flags
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      unknown_o <= 1'b0;
    end
    else
    begin
      // Busy covers every cycle in which a new instruction is refused
      busy_o    <= take_inv || ((state != btob_pkg::ST_IDLE) && (state != btob_pkg::ST_WRITE));
      done_o    <= take_br || (state == btob_pkg::ST_WRITE);
      unknown_o <= instr_valid_i && (state == btob_pkg::ST_IDLE) && !is_invert && !is_branch;
    end
  end

  sequence s_read;
    dmem_rd_o && !dmem_wr_o;
  endsequence

  sequence s_mod;
    !dmem_rd_o && !dmem_wr_o;
  endsequence

  sequence s_write;
    dmem_wr_o && !dmem_rd_o;
  endsequence

  a_rmw_sequence: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    take_inv |=> s_read ##1 s_mod ##1 s_write ##1 (done_o && !dmem_wr_o))
    else $error("bit invert sequence broken");

  a_toggle_one_bit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state == btob_pkg::ST_MOD) |=> (dmem_wdata_o == ($past(dmem_rdata_i) ^ $past(bit_mask))))
    else $error("written byte is not read byte with one bit flipped");

  a_mask_one_hot: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    dmem_wr_o |-> $onehot(dmem_wdata_o ^ $past(dmem_rdata_i)))
    else $error("more or fewer than one bit changed");

  a_bank_reg_sel: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (take_inv && instr_i[8]) |=> (dmem_addr_o == {$past(bank_select_reg_i), $past(instr_i[7:0])}))
    else $error("banked address wrong");

  a_access_bank: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (take_inv && !instr_i[8] && !(ext_set_en_i && instr_i[7:0] <= `BTOB_IDX_LIMIT))
    |=> (dmem_addr_o[7:0] == $past(instr_i[7:0])) &&
        (dmem_addr_o[11:8] == ($past(instr_i[7]) ? `BTOB_ACC_HI_BANK : `BTOB_ACC_LO_BANK)))
    else $error("access bank address wrong");

  a_indexed_mode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (take_inv && !instr_i[8] && ext_set_en_i && instr_i[7:0] <= `BTOB_IDX_LIMIT)
    |=> (dmem_addr_o == $past(index_base_i) + {4'h0, $past(instr_i[7:0])}))
    else $error("indexed literal offset address wrong");

  a_branch_taken: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (take_br && ovf_flag_i) |=> pc_load_o && done_o &&
      (pc_o == $past(instr_addr_i) + `BTOB_PC_STEP +
               {{12{$past(instr_i[7])}}, $past(instr_i[7:0]), 1'b0}))
    else $error("taken branch did not load target");

  a_offset_extreme: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (take_br && ovf_flag_i && instr_i[7:0] == 8'h80)
    |=> (pc_o == $past(instr_addr_i) + `BTOB_PC_STEP - 21'h000100))
    else $error("most negative offset not doubled");

  a_no_branch: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (take_br && !ovf_flag_i) |=> !pc_load_o && done_o &&
      (pc_o == $past(instr_addr_i) + `BTOB_PC_STEP))
    else $error("untaken branch changed flow");

  sequence s_busy_run;
    busy_o [*3] ##1 !busy_o;
  endsequence

  a_busy_window: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    take_inv |=> s_busy_run)
    else $error("busy does not cover the refusal window");

  a_rmw_same_addr: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    dmem_wr_o |-> $past(dmem_rd_o, 2) && (dmem_addr_o == $past(dmem_addr_o, 2)))
    else $error("write back not to the address read");

  a_unknown_quiet: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (instr_valid_i && state == btob_pkg::ST_IDLE && instr_i[15:12] != `BTOB_INV_PREFIX &&
     instr_i[15:8] != `BTOB_BR_PREFIX) |=> unknown_o && !done_o && !dmem_rd_o && !pc_load_o)
    else $error("undecoded instruction caused activity");

  a_load_only_taken: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(take_br && ovf_flag_i) |=> !pc_load_o)
    else $error("program counter loaded without taken branch");

endmodule // btob_core

// File: btob_regs.svh
// Constants of the bit-invert and branch-on-overflow execute block
`ifndef BTOB_REGS_SVH
`define BTOB_REGS_SVH

`define BTOB_INV_PREFIX   4'h7
`define BTOB_BR_PREFIX    8'h04
`define BTOB_IDX_LIMIT    8'h5F
`define BTOB_ACC_SPLIT    8'h80
`define BTOB_ACC_HI_BANK  4'hF
`define BTOB_ACC_LO_BANK  4'h0
`define BTOB_PC_STEP      21'h000002
`define BTOB_PC_W         21
`define BTOB_DADDR_W      12

`endif

// File: btob_pkg.sv
// Types of the bit-invert and branch-on-overflow execute block
package btob_pkg;

  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'h1,
    ST_READ  = 4'h2,
    ST_MOD   = 4'h4,
    ST_WRITE = 4'h8
  } btob_state_t;

  typedef logic [7:0]  btob_byte_t;
  typedef logic [11:0] btob_daddr_t;
  typedef logic [20:0] btob_pc_t;

endpackage

// File: btob_addr_if.sv
// Operand address request and answer between core and address former
interface btob_addr_if;
  btob_pkg::btob_byte_t file_off;
  logic                 bank_sel;
  logic                 ext_en;
  logic [3:0]           bank_reg;
  btob_pkg::btob_daddr_t index_base;
  btob_pkg::btob_daddr_t data_addr;
  logic                 indexed;

  modport calc
  (
    input  file_off,
    input  bank_sel,
    input  ext_en,
    input  bank_reg,
    input  index_base,
    output data_addr,
    output indexed
  );

  modport core
  (
    output file_off,
    output bank_sel,
    output ext_en,
    output bank_reg,
    output index_base,
    input  data_addr,
    input  indexed
  );
endinterface

// File: btob_addr_calc.sv
// Data-memory operand address former for bit-oriented instructions
`include "btob_regs.svh"

module btob_addr_calc
(
  btob_addr_if.calc aif
);

  always_comb
  begin
    aif.indexed = aif.ext_en && !aif.bank_sel && (aif.file_off <= `BTOB_IDX_LIMIT);
    if (aif.indexed)
    begin
      aif.data_addr = aif.index_base + {4'h0, aif.file_off};
    end
    else if (aif.bank_sel)
    begin
      aif.data_addr = {aif.bank_reg, aif.file_off};
    end
    else if (aif.file_off >= `BTOB_ACC_SPLIT)
    begin
      aif.data_addr = {`BTOB_ACC_HI_BANK, aif.file_off};
    end
    else
    begin
      aif.data_addr = {`BTOB_ACC_LO_BANK, aif.file_off};
    end
  end

endmodule // btob_addr_calc

// File: test_btob_core.sv
// Self-checking bench for the bit-invert and branch-on-overflow block
module test_btob_core;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk_i, rstn_i, instr_valid_i, ovf_flag_i, ext_set_en_i;
  logic [15:0] instr_i;
  logic [20:0] instr_addr_i, pc_o;
  logic [3:0]  bank_select_reg_i;
  logic [11:0] index_base_i, dmem_addr_o;
  logic [7:0]  dmem_rdata_i, dmem_wdata_o;
  logic        dmem_rd_o, dmem_wr_o, pc_load_o, busy_o, done_o, unknown_o;
  int          n_mismatch = 0;
  int          compares = 0;

  btob_core btob_core_i
  (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_addr_i(instr_addr_i), .ovf_flag_i(ovf_flag_i), .ext_set_en_i(ext_set_en_i),
    .bank_select_reg_i(bank_select_reg_i), .index_base_i(index_base_i),
    .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o), .dmem_rdata_i(dmem_rdata_i),
    .dmem_wr_o(dmem_wr_o), .dmem_wdata_o(dmem_wdata_o), .pc_load_o(pc_load_o),
    .pc_o(pc_o), .busy_o(busy_o), .done_o(done_o), .unknown_o(unknown_o)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // Caller stands at a falling edge; a branch is held up during busy to prove it is ignored
  task automatic invert(input logic [2:0] b, input logic a, input logic [7:0] f,
                        input logic ext, input logic [7:0] data);
    logic [11:0] ea;
    int          rd_at = 0;
    int          wr_at = 0;
    int          done_at = 0;
    int          stray = 0;
    logic [6:0]  busy_seen = 7'h00;
    if (ext && !a && f <= 8'h5F)
      ea = index_base_i + 12'(f);
    else if (a)
      ea = {bank_select_reg_i, f};
    else
      ea = (f >= 8'h80) ? {4'hF, f} : {4'h0, f};
    ext_set_en_i = ext;
    ovf_flag_i = 1'b1;
    instr_i = {4'h7, b, a, f};
    instr_valid_i = 1'b1;
    for (int k = 1; k <= 6; k++)
    begin
      @(negedge mclk_i);
      if (k == 1)
        instr_i = 16'h0410;
      if (k == 3)
        instr_valid_i = 1'b0;
      // Memory answers only in the cycle after the strobe
      if (k == 2 && rd_at == 1)
        dmem_rdata_i = data;
      stray += (pc_load_o === 1'b1 || unknown_o === 1'b1);
      busy_seen[k] = busy_o;
      if (dmem_rd_o === 1'b1)
      begin
        rd_at = k;
        dmem_rdata_i = ~data;
        chk("dmem_addr_o", ea, dmem_addr_o);
      end
      if (dmem_wr_o === 1'b1)
      begin
        wr_at = k;
        dmem_rdata_i = ~data;
        chk("dmem_wdata_o", data ^ (8'h01 << b), dmem_wdata_o);
        chk("dmem_addr_o at write", ea, dmem_addr_o);
      end
      if (done_o === 1'b1)
        done_at = k;
    end
    chk("read cycle", 1, rd_at);
    chk("write cycle", 3, wr_at);
    chk("done cycle", 4, done_at);
    chk("ignored while busy", 0, stray);
    chk("busy_o cycles", 7'h0E, busy_seen);
  endtask

  task automatic reset_phase();
    rstn_i = 1'b0;
    instr_valid_i = 1'b0;
    repeat (5) @(negedge mclk_i);
    chk("outputs in reset", 0, {done_o, dmem_rd_o, dmem_wr_o, pc_load_o, busy_o, unknown_o});
    chk("pc_o in reset", 0, pc_o);
    chk("dmem_addr_o in reset", 0, dmem_addr_o);
    rstn_i = 1'b1;
    @(negedge mclk_i);
  endtask

  task automatic branch(input logic [7:0] n, input logic ovf, input logic [20:0] at,
                        input logic last);
    logic [20:0] exp;
    exp = at + 21'h000002 + (ovf ? {{12{n[7]}}, n, 1'b0} : 21'h000000);
    instr_i = {8'h04, n};
    instr_addr_i = at;
    ovf_flag_i = ovf;
    instr_valid_i = 1'b1;
    @(negedge mclk_i);
    chk("done_o", 1'b1, done_o);
    chk("pc_load_o", ovf, pc_load_o);
    chk("pc_o", exp, pc_o);
    chk("dmem_wr_o", 1'b0, dmem_wr_o);
    if (last)
    begin
      instr_valid_i = 1'b0;
      @(negedge mclk_i);
    end
  endtask

  task automatic other();
    instr_i = 16'hC123;
    instr_valid_i = 1'b1;
    @(negedge mclk_i);
    instr_valid_i = 1'b0;
    chk("unknown_o", 1'b1, unknown_o);
    chk("quiet on unknown", 0, {done_o, pc_load_o, dmem_rd_o});
  endtask

  initial
  begin
    rstn_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    instr_addr_i = 21'h000000;
    ovf_flag_i = 1'b0;
    ext_set_en_i = 1'b0;
    bank_select_reg_i = 4'h3;
    index_base_i = 12'h4A0;
    dmem_rdata_i = 8'h00;
    reset_phase();
    for (int b = 0; b < 8; b++)
      invert(3'(b), 1'b1, 8'h3C, 1'b0, 8'hA5);
    invert(3'h7, 1'b0, 8'h85, 1'b0, 8'h0F);
    invert(3'h0, 1'b0, 8'h20, 1'b0, 8'hFF);
    invert(3'h4, 1'b0, 8'h5F, 1'b1, 8'h00);
    invert(3'h2, 1'b0, 8'h60, 1'b1, 8'h44);
    invert(3'h5, 1'b1, 8'h10, 1'b1, 8'hC3);
    branch(8'h7F, 1'b1, 21'h000100, 1'b0);
    branch(8'h80, 1'b1, 21'h000100, 1'b0);
    branch(8'hFF, 1'b0, 21'h001FFE, 1'b0);
    branch(8'h05, 1'b1, 21'h1FFFF0, 1'b1);
    reset_phase();
    other();
    end_of_test();
  end
endmodule // test_btob_core
